// [src/odsc_pkg.sv]
// Package for the output diagnostic status and mask configuration block
package odsc_pkg;

  localparam int unsigned ODSC_NUM_HS = 5;
  localparam int unsigned ODSC_CLK_HZ = 40_000_000;
  // Open-load filter time in microseconds, and the cycles it takes
  localparam int unsigned ODSC_OL_FILTER_US = 1000;
  localparam int unsigned ODSC_OL_FILTER_CYC = (ODSC_OL_FILTER_US * (ODSC_CLK_HZ / 1_000_000));
  localparam int unsigned ODSC_OL_CNT_W = 16;

  // Status word layout
  localparam int unsigned ODSC_ST_PAIR_TOP = 15;
  localparam int unsigned ODSC_ST_PAIR_LOW = 6;
  localparam int unsigned ODSC_ST_UV_BIT = 3;
  localparam int unsigned ODSC_ST_OV_BIT = 2;

  // Configuration word layout
  localparam int unsigned ODSC_CFG_HS1_UC_MASK = 5;
  localparam int unsigned ODSC_CFG_LS1_UC_MASK = 4;
  localparam int unsigned ODSC_CFG_TW_MASK = 3;
  localparam int unsigned ODSC_CFG_OL_MASK = 1;
  localparam logic [15:0] ODSC_CFG_WMASK = 16'h003A;
  localparam logic [15:0] ODSC_CFG_RESET = 16'h0000;

  // Global status byte positions
  localparam int unsigned ODSC_GS_TW_BIT = 3;
  localparam int unsigned ODSC_GS_OL_BIT = 1;

  // Recovery-inhibit bit position in the third control word
  localparam int unsigned ODSC_CTL3_RECOV_INH = 4;

  typedef enum logic [1:0] {
    ODSC_OUT_ON = 2'b00,
    ODSC_OUT_TRIP = 2'b01,
    ODSC_OUT_WAIT = 2'b11
  } odsc_out_st_t;

  // Per-output analog comparator results
  typedef struct packed {
    logic overcurrent;
    logic undercurrent;
  } odsc_sense_t;

endpackage : odsc_pkg

// [src/odsc_top.sv]
// Over/under-current and supply diagnostics with mask configuration
// Functional notes
// - Over-current sets the output's flag and switches that driver off.
// - With recovery enabled, a tripped output restarts itself after a delay.
// - With recovery disabled, output stays off until its flag is cleared.
// - Under-current flag set after current stays low for the filter time.
// - Supply over/under-voltage sets flag bit 2/3 and turns outputs off.
// - Outputs return automatically on supply recovery unless inhibit bit set.
// - Status word is read-only, 16 bits, pairs in bits 15..6.
// - Config bit 5 hides first high-side under-current from open-load summary.
// - Config bit 4 hides first low-side under-current from open-load summary.
// - Config bit 3 keeps temperature warning from global error flag.
// - Config bit 1 keeps open-load summary from global error flag.
// - Configuration word reads back the last written mask value.
`timescale 1ns/1ps
module odsc_top
  import odsc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Analog comparators (asynchronous)
  input wire odsc_sense_t [ODSC_NUM_HS-1:0] sense_i,
  input wire logic supply_ov_i,
  input wire logic supply_uv_i,
  // Output requests and recovery controls
  input wire logic [ODSC_NUM_HS-1:0] out_req_i,
  input wire logic oc_recovery_en_i,
  input wire logic oc_recovery_tick_i,
  input wire logic [15:0] ctrl3_word_i,
  // Inputs from other status words for the global byte
  input wire logic hs1_uc_flag_i,
  input wire logic ls1_uc_flag_i,
  input wire logic other_uc_any_i,
  input wire logic temp_warn_i,
  input wire logic other_err_i,
  // Serial register access
  input wire logic status_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic [ODSC_NUM_HS-1:0] oc_clear_i,
  // Results
  output logic [15:0] status_word_o,
  output logic [15:0] cfg_word_o,
  output logic [ODSC_NUM_HS-1:0] out_en_o,
  output logic open_load_sum_o,
  output logic global_err_o
);

  // Two-stage synchronisers for all analog inputs
  localparam int unsigned SW = 2 * ODSC_NUM_HS + 2;
  logic [SW-1:0] sync1_ff, sync2_ff;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {supply_ov_i, supply_uv_i, sense_i};
      sync2_ff <= sync1_ff;
    end
  end

  odsc_sense_t [ODSC_NUM_HS-1:0] sense_s;
  logic ov_s, uv_s;
  assign sense_s = sync2_ff[SW-3:0];
  assign uv_s = sync2_ff[SW-2];
  assign ov_s = sync2_ff[SW-1];

  // State registers
  odsc_out_st_t st_ff [ODSC_NUM_HS];
  odsc_out_st_t nxt_st [ODSC_NUM_HS];
  logic [ODSC_NUM_HS-1:0] oc_ff, nxt_oc, uc_ff, nxt_uc, en_ff, nxt_en;
  logic [ODSC_OL_CNT_W-1:0] olcnt_ff [ODSC_NUM_HS];
  logic [ODSC_OL_CNT_W-1:0] nxt_olcnt [ODSC_NUM_HS];
  logic ov_ff, nxt_ov, uv_ff, nxt_uv, sup_off_ff, nxt_sup_off;
  logic [15:0] cfg_ff, nxt_cfg, stat_ff, nxt_stat;
  logic ol_ff, nxt_ol, err_ff, nxt_err;

  always_comb begin
    nxt_ov = ov_ff;
    nxt_uv = uv_ff;
    nxt_sup_off = sup_off_ff;
    // Supply flags are sticky until read; a new event wins over the read clear
    if (status_rd_i) begin
      nxt_ov = 1'b0;
      nxt_uv = 1'b0;
    end
    if (ov_s) nxt_ov = 1'b1;
    if (uv_s) nxt_uv = 1'b1;
    if (ov_s || uv_s) begin
      nxt_sup_off = 1'b1;
    end else if (!ctrl3_word_i[ODSC_CTL3_RECOV_INH]) begin
      nxt_sup_off = 1'b0;
    end else if (!ov_ff && !uv_ff) begin
      // Inhibited: restart only once software has read the supply flags away
      nxt_sup_off = 1'b0;
    end

    for (int i = 0; i < ODSC_NUM_HS; i++) begin
      nxt_st[i] = st_ff[i];
      nxt_oc[i] = oc_ff[i];
      nxt_uc[i] = uc_ff[i];
      nxt_olcnt[i] = olcnt_ff[i];
      if (oc_clear_i[i]) nxt_oc[i] = 1'b0;
      case (st_ff[i])
        ODSC_OUT_ON: begin
          if (sense_s[i].overcurrent && en_ff[i]) begin
            nxt_oc[i] = 1'b1;
            nxt_st[i] = ODSC_OUT_TRIP;
          end
        end
        ODSC_OUT_TRIP: begin
          if (oc_recovery_en_i) begin
            nxt_st[i] = ODSC_OUT_WAIT;
          end else if (!oc_ff[i]) begin
            nxt_st[i] = ODSC_OUT_ON;
          end
        end
        ODSC_OUT_WAIT: begin
          // Dropping recovery mid-wait falls back to the clear-to-restart path
          if (!oc_recovery_en_i) begin
            nxt_st[i] = ODSC_OUT_TRIP;
          end else if (oc_recovery_tick_i) begin
            // Delay tick comes from the duty-cycle generator in the control block
            nxt_st[i] = ODSC_OUT_ON;
          end
        end
        default: nxt_st[i] = ODSC_OUT_ON;
      endcase
      // Filter counts only while the stage is actively driven
      if (en_ff[i] && sense_s[i].undercurrent) begin
        if (olcnt_ff[i] < ODSC_OL_CNT_W'(ODSC_OL_FILTER_CYC - 1)) begin
          nxt_olcnt[i] = olcnt_ff[i] + 1'b1;
        end else begin
          nxt_uc[i] = 1'b1;
        end
      end else begin
        nxt_olcnt[i] = '0;
        if (status_rd_i) nxt_uc[i] = 1'b0;
      end
      nxt_en[i] = out_req_i[i] && (nxt_st[i] == ODSC_OUT_ON) && !nxt_sup_off;
    end

    nxt_cfg = cfg_wr_i ? (cfg_wdata_i & ODSC_CFG_WMASK) : cfg_ff;

    nxt_stat = '0;
    for (int i = 0; i < ODSC_NUM_HS; i++) begin
      nxt_stat[ODSC_ST_PAIR_TOP - 2*i] = nxt_oc[i];
      nxt_stat[ODSC_ST_PAIR_TOP - 2*i - 1] = nxt_uc[i];
    end
    nxt_stat[ODSC_ST_UV_BIT] = nxt_uv;
    nxt_stat[ODSC_ST_OV_BIT] = nxt_ov;

    nxt_ol = (hs1_uc_flag_i && !nxt_cfg[ODSC_CFG_HS1_UC_MASK])
          || (ls1_uc_flag_i && !nxt_cfg[ODSC_CFG_LS1_UC_MASK])
          || other_uc_any_i || (|nxt_uc);
    nxt_err = other_err_i || (|nxt_oc) || nxt_ov || nxt_uv
           || (temp_warn_i && !nxt_cfg[ODSC_CFG_TW_MASK])
           || (nxt_ol && !nxt_cfg[ODSC_CFG_OL_MASK]);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < ODSC_NUM_HS; i++) begin
        st_ff[i] <= ODSC_OUT_ON;
        olcnt_ff[i] <= '0;
      end
      oc_ff <= '0;
      uc_ff <= '0;
      en_ff <= '0;
      ov_ff <= 1'b0;
      uv_ff <= 1'b0;
      sup_off_ff <= 1'b0;
      cfg_ff <= ODSC_CFG_RESET;
      stat_ff <= '0;
      ol_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      olcnt_ff <= nxt_olcnt;
      oc_ff <= nxt_oc;
      uc_ff <= nxt_uc;
      en_ff <= nxt_en;
      ov_ff <= nxt_ov;
      uv_ff <= nxt_uv;
      sup_off_ff <= nxt_sup_off;
      cfg_ff <= nxt_cfg;
      stat_ff <= nxt_stat;
      ol_ff <= nxt_ol;
      err_ff <= nxt_err;
    end
  end

  assign status_word_o = stat_ff;
  assign cfg_word_o = cfg_ff;
  assign out_en_o = en_ff;
  assign open_load_sum_o = ol_ff;
  assign global_err_o = err_ff;

  // Checks
  a_oc_trip_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff[0] == ODSC_OUT_ON && en_ff[0] && sense_s[0].overcurrent)
      |=> (oc_ff[0] && !en_ff[0])) else $error("overcurrent did not trip output");
  a_oc_recov_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff[0] != ODSC_OUT_ON && oc_ff[0] && !oc_recovery_en_i && !oc_clear_i[0]) |=> !en_ff[0])
    else $error("output re-enabled without flag clear");
  a_oc_auto_back: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff[0] == ODSC_OUT_WAIT && oc_recovery_en_i && oc_recovery_tick_i) |=> st_ff[0] == ODSC_OUT_ON)
    else $error("recovery did not restart output");
  a_uc_filter: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(uc_ff[0]) |-> olcnt_ff[0] == ODSC_OL_CNT_W'(ODSC_OL_FILTER_CYC - 1))
    else $error("undercurrent set before filter time");
  a_sup_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (ov_s || uv_s) |=> (en_ff == '0 && (ov_ff || uv_ff)))
    else $error("supply fault left outputs on");
  a_sup_back: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (sup_off_ff && !ov_s && !uv_s && !ctrl3_word_i[ODSC_CTL3_RECOV_INH]) |=> !sup_off_ff)
    else $error("supply recovery did not release outputs");
  a_stat_rsvd: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    stat_ff[5:4] == 2'b00 && stat_ff[1:0] == 2'b00)
    else $error("reserved status bits nonzero");
  a_stat_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ##1 (stat_ff[ODSC_ST_PAIR_TOP] == oc_ff[0] && stat_ff[ODSC_ST_PAIR_LOW] == uc_ff[4]))
    else $error("status pair mapping wrong");
  a_cfg_readback: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cfg_wr_i |=> cfg_ff == (($past(cfg_wdata_i)) & ODSC_CFG_WMASK))
    else $error("config readback mismatch");
  a_hs1_mask: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (cfg_ff[ODSC_CFG_HS1_UC_MASK] && !cfg_wr_i && hs1_uc_flag_i && !ls1_uc_flag_i
     && !other_uc_any_i && nxt_uc == '0) |=> !ol_ff)
    else $error("masked high-side undercurrent reached summary");
  a_ls1_mask: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (cfg_ff[ODSC_CFG_LS1_UC_MASK] && !cfg_wr_i && ls1_uc_flag_i && !hs1_uc_flag_i
     && !other_uc_any_i && nxt_uc == '0) |=> !ol_ff)
    else $error("masked low-side undercurrent reached summary");
  a_err_masks: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (cfg_ff[ODSC_CFG_TW_MASK] && cfg_ff[ODSC_CFG_OL_MASK] && !cfg_wr_i && !other_err_i
     && nxt_oc == '0 && !nxt_ov && !nxt_uv) |=> !err_ff)
    else $error("masked event raised global error");

endmodule : odsc_top

// [verification/odsc_mcu_model.sv]
// Controller-side model: configuration, status reads and output requests
`timescale 1ns/1ps
module odsc_mcu_model
  import odsc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register side
  output logic cfg_wr_o,
  output logic [15:0] cfg_wdata_o,
  output logic status_rd_o,
  output logic [ODSC_NUM_HS-1:0] oc_clear_o,
  // Output control
  output logic [ODSC_NUM_HS-1:0] out_req_o,
  output logic rec_en_o,
  output logic rec_tick_o,
  output logic [15:0] ctrl3_o
);
  initial begin
    cfg_wr_o = 1'b0;
    cfg_wdata_o = 16'h0000;
    status_rd_o = 1'b0;
    oc_clear_o = '0;
    out_req_o = '0;
    rec_en_o = 1'b0;
    rec_tick_o = 1'b0;
    ctrl3_o = 16'h0000;
  end

  // Reserved bits are the caller's choice, so a refusal can be provoked
  task automatic cfg_write(input logic [15:0] d);
    @(posedge clk_i) #1;
    cfg_wr_o = 1'b1;
    cfg_wdata_o = d;
    @(posedge clk_i) #1;
    cfg_wr_o = 1'b0;
    cfg_wdata_o = ~d;
  endtask : cfg_write

  // One-cycle strobes; a cleared flag is the only restart path without recovery
  task automatic strobe(input logic rd, input logic [ODSC_NUM_HS-1:0] clr, input logic tk);
    @(posedge clk_i) #1;
    status_rd_o = rd;
    oc_clear_o = clr;
    rec_tick_o = tk;
    @(posedge clk_i) #1;
    status_rd_o = 1'b0;
    oc_clear_o = '0;
    rec_tick_o = 1'b0;
  endtask : strobe
endmodule : odsc_mcu_model

// [verification/odsc_top_tb.sv]
// Self-checking bench for the diagnostic status and mask block
`timescale 1ns/1ps
module odsc_top_tb;
  import odsc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  odsc_sense_t [ODSC_NUM_HS-1:0] sense = '0;
  logic ov = 1'b0, uv = 1'b0, hs1_uc = 1'b0, ls1_uc = 1'b0, temp_warn = 1'b0;
  logic cfg_wr, status_rd, rec_en, rec_tick;
  logic [15:0] cfg_wdata, ctrl3, status_word, cfg_word;
  logic [ODSC_NUM_HS-1:0] oc_clear, out_req, out_en;
  logic ol_sum, gerr;
  int num_errors = 0;
  int tests_run = 0;

  always #12.5 sys_clk = ~sys_clk;

  odsc_mcu_model MCU (.clk_i(sys_clk), .cfg_wr_o(cfg_wr), .cfg_wdata_o(cfg_wdata),
    .status_rd_o(status_rd), .oc_clear_o(oc_clear), .out_req_o(out_req),
    .rec_en_o(rec_en), .rec_tick_o(rec_tick), .ctrl3_o(ctrl3));

  odsc_top DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .sense_i(sense),
    .supply_ov_i(ov), .supply_uv_i(uv), .out_req_i(out_req), .oc_recovery_en_i(rec_en),
    .oc_recovery_tick_i(rec_tick), .ctrl3_word_i(ctrl3), .hs1_uc_flag_i(hs1_uc),
    .ls1_uc_flag_i(ls1_uc), .other_uc_any_i(1'b0), .temp_warn_i(temp_warn),
    .other_err_i(1'b0), .status_rd_i(status_rd), .cfg_wr_i(cfg_wr),
    .cfg_wdata_i(cfg_wdata), .oc_clear_i(oc_clear), .status_word_o(status_word),
    .cfg_word_o(cfg_word), .out_en_o(out_en), .open_load_sum_o(ol_sum),
    .global_err_o(gerr));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic mask_case(input logic [15:0] cfg, input logic exp_ol, input logic exp_err);
    MCU.cfg_write(cfg);
    cyc(3);
    check("open_load_sum", {15'h0000, ol_sum}, {15'h0000, exp_ol});
    check("global_err", {15'h0000, gerr}, {15'h0000, exp_err});
  endtask : mask_case

  task automatic test_cfg_masks();
    MCU.cfg_write(16'hFFFF);
    cyc(1);
    check("cfg_word", cfg_word, 16'h003A);
    temp_warn = 1'b1;
    mask_case(16'h0000, 1'b0, 1'b1);
    mask_case(16'h0008, 1'b0, 1'b0);
    temp_warn = 1'b0;
    hs1_uc = 1'b1;
    mask_case(16'h0000, 1'b1, 1'b1);
    mask_case(16'h0020, 1'b0, 1'b0);
    hs1_uc = 1'b0;
    ls1_uc = 1'b1;
    mask_case(16'h0010, 1'b0, 1'b0);
    mask_case(16'h0002, 1'b1, 1'b0);
    ls1_uc = 1'b0;
    MCU.cfg_write(16'h0000);
    $display("test cfg_masks done");
  endtask : test_cfg_masks

  task automatic test_overcurrent();
    MCU.out_req_o = 5'h1F;
    cyc(3);
    check("out_en", {11'h000, out_en}, 16'h001F);
    sense[0].overcurrent = 1'b1;
    cyc(4);
    check("status", status_word, 16'h8000);
    check("out_en", {11'h000, out_en}, 16'h001E);
    sense[0].overcurrent = 1'b0;
    cyc(4);
    check("out_en", {11'h000, out_en}, 16'h001E);
    MCU.strobe(1'b0, 5'h01, 1'b0);
    cyc(3);
    check("out_en", {11'h000, out_en}, 16'h001F);
    MCU.rec_en_o = 1'b1;
    sense[0].overcurrent = 1'b1;
    cyc(4);
    check("out_en", {11'h000, out_en}, 16'h001E);
    sense[0].overcurrent = 1'b0;
    MCU.strobe(1'b0, 5'h00, 1'b1);
    MCU.strobe(1'b0, 5'h00, 1'b1);
    cyc(3);
    check("out_en", {11'h000, out_en}, 16'h001F);
    check("status", status_word, 16'h8000);
    MCU.strobe(1'b0, 5'h01, 1'b0);
    MCU.rec_en_o = 1'b0;
    $display("test overcurrent done");
  endtask : test_overcurrent

  task automatic test_supply();
    uv = 1'b1;
    cyc(4);
    check("status", status_word, 16'h0008);
    check("out_en", {11'h000, out_en}, 16'h0000);
    uv = 1'b0;
    cyc(4);
    check("out_en", {11'h000, out_en}, 16'h001F);
    MCU.ctrl3_o = 16'h0010;
    MCU.strobe(1'b1, 5'h00, 1'b0);
    ov = 1'b1;
    cyc(4);
    ov = 1'b0;
    cyc(4);
    check("status", status_word, 16'h0004);
    check("out_en", {11'h000, out_en}, 16'h0000);
    MCU.strobe(1'b1, 5'h00, 1'b0);
    cyc(4);
    check("out_en", {11'h000, out_en}, 16'h001F);
    MCU.ctrl3_o = 16'h0000;
    $display("test supply done");
  endtask : test_supply

  // Filter is a fixed 40000 cycles, so this test dominates the run time
  task automatic test_undercurrent();
    sense[0].undercurrent = 1'b1;
    cyc(39990);
    check("status", status_word, 16'h0000);
    cyc(20);
    check("status", status_word, 16'h4000);
    check("reserved", status_word & 16'h0033, 16'h0000);
    // Dropping the output does not clear it: the flag stays until read after the output drops
    MCU.out_req_o = 5'h00;
    cyc(3);
    check("status", status_word, 16'h4000);
    MCU.strobe(1'b1, 5'h00, 1'b0);
    cyc(1);
    check("status", status_word, 16'h0000);
    $display("test undercurrent done");
  endtask : test_undercurrent

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge sys_clk);
    #1 resetn = 1'b1;
    test_cfg_masks();
    test_overcurrent();
    test_supply();
    test_undercurrent();
    final_report();
  end

  initial begin
    #1_500_000;
    num_errors++;
    final_report();
  end
endmodule : odsc_top_tb
